// File: inc/wkd_pkg.sv
// package for the wake input detector: register map, field layout, timing
// assumes a 25 MHz clock and a classic wishbone slave with 32-bit data
package wkd_pkg;
    // ==================================================================
    // bus geometry
    localparam int WKD_AW = 8;
    localparam int WKD_DW = 32;
    localparam int WKD_PINS = 3;
    // ==================================================================
    // register byte offsets
    localparam logic [7:0] WKD_OFS_ENABLE = 8'h00; // wake_enable_control
    localparam logic [7:0] WKD_OFS_STAT_A = 8'h04; // wake_source_status_a
    localparam logic [7:0] WKD_OFS_STAT_B = 8'h08; // wake_source_status_b
    localparam logic [7:0] WKD_OFS_LEVEL = 8'h0c; // pin_level_status
    localparam logic [7:0] WKD_OFS_PULL = 8'h10; // pull_source_control
    localparam logic [7:0] WKD_OFS_FILT = 8'h14; // detection_filter_control
    localparam logic [7:0] WKD_OFS_MASK = 8'h18; // interrupt mask
    localparam logic [7:0] WKD_OFS_MODE = 8'h1c; // power mode
    // ==================================================================
    // reset values
    localparam logic [2:0] WKD_RST_ENABLE = 3'h0;
    localparam logic [5:0] WKD_RST_PULL = 6'h00; // all pulls off
    localparam logic [5:0] WKD_RST_FILT = 6'h00; // static, short filter
    localparam logic [4:0] WKD_RST_MASK = 5'h00;
    localparam logic [1:0] WKD_RST_MODE = 2'h0;
    // ==================================================================
    // field codes: two bits per pin, pin n at bits [2n+1:2n]
    localparam int WKD_FLD_W = 2;
    localparam logic [1:0] WKD_DET_STAT_SHORT = 2'h0;
    localparam logic [1:0] WKD_DET_STAT_LONG = 2'h1;
    localparam logic [1:0] WKD_DET_CYC_ONE = 2'h2;
    localparam logic [1:0] WKD_DET_CYC_TWO = 2'h3;
    localparam logic [1:0] WKD_PULL_NONE = 2'h0;
    localparam logic [1:0] WKD_PULL_DOWN = 2'h1;
    localparam logic [1:0] WKD_PULL_UP = 2'h2;
    localparam logic [1:0] WKD_PULL_AUTO = 2'h3;
    // ==================================================================
    // power modes
    typedef enum logic [1:0] {
        WKD_MODE_NORMAL = 2'b00,
        WKD_MODE_STOP = 2'b01,
        WKD_MODE_SLEEP = 2'b10,
        WKD_MODE_FAILSAFE = 2'b11
    } wkd_mode_t;
    // ==================================================================
    // timing
    localparam int WKD_CLK_MHZ = 25;
    localparam int WKD_T_SHORT_US = 16;
    localparam int WKD_T_LONG_US = 64;
    localparam int WKD_CYC_SHORT = WKD_T_SHORT_US * WKD_CLK_MHZ; // 400
    localparam int WKD_CYC_LONG = WKD_T_LONG_US * WKD_CLK_MHZ; // 1600
    localparam int WKD_CNT_W = 11;
endpackage

// File: verilog/wkd_filter.sv
// one wake input filter: detects both edges and confirms them after a
// programmable stable time; assumes pin and window are clk_i synchronous
`timescale 1ns/1ps
`default_nettype none
module wkd_filter #(
    parameter int CNT_W = wkd_pkg::WKD_CNT_W
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic pin_i,
    input wire logic window_i,
    input wire logic [CNT_W-1:0] limit_i,
    output logic level_o,
    output logic edge_o
);
    import wkd_pkg::*;
    // ==================================================================
    // state
    logic level_q; // accepted level
    logic [CNT_W-1:0] cnt_q; // cycles that the new level has stood
    logic edge_q;
    // a level that differs from the accepted one and stands for limit_i
    // cycles is taken; a cross back restarts the count
    wire logic differ = window_i && (pin_i != level_q);
    wire logic done = differ && (cnt_q >= limit_i - CNT_W'(1));
    // ==================================================================
    // filter counter
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            level_q <= 1'b0;
            cnt_q <= '0;
            edge_q <= 1'b0;
        end else begin
            edge_q <= done; // R1 both directions count
            if (done) begin // R5
                level_q <= pin_i;
                cnt_q <= '0;
            end else if (differ) begin
                cnt_q <= cnt_q + CNT_W'(1);
            end else begin
                cnt_q <= '0; // crossed back or window closed
            end
        end
    end
    assign level_o = level_q;
    assign edge_o = edge_q;

    // ==================================================================
    // checks
    AST_FILT_RESTART: assert property ( // R5
        @(posedge clk_i) disable iff (rst_i)
        !differ |=> cnt_q == '0) else $error("filter count not cleared");
    AST_FILT_EDGE: assert property ( // R1
        @(posedge clk_i) disable iff (rst_i)
        edge_o |-> level_q != $past(level_q))
        else $error("edge without level change");
endmodule
`default_nettype wire

// File: verilog/wkd_core.sv
// What this block does
// R1: both edges of a wake pin signal
// R2: normal/stop interrupt, sleep/failsafe wake request
// R3: static sense watches pins all time
// R4: cyclic sense evaluates only in timer window
// R5: wake taken only if stable whole filter
// R6: code 00 16us, code 01 64us static
// R7: code 10 timer one, 11 timer two
// R8: per-pin wake enable gates wake ability
// R9: per-pin source flags in status a
// R10: levels readable in normal and stop
// R11: cyclic sense reports last window sample
// R12: fail-output inputs fixed 16us, status b
// R13: pull field 00 none 01 down 10 up 11 auto
// R14: auto pull follows detected pin level
// R15: flags stay until host writes one
//
// top of the wake input detector; classic wishbone slave, one clock;
// cyclic windows come from outside timers as synchronous levels
`timescale 1ns/1ps
`default_nettype none
module wkd_core #(
    parameter int PINS = wkd_pkg::WKD_PINS
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [wkd_pkg::WKD_AW-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [wkd_pkg::WKD_DW-1:0] wb_dat_i,
    output logic [wkd_pkg::WKD_DW-1:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    // pins and windows
    input wire logic [PINS-1:0] wake_pin_n_i, // comparator outputs
    input wire logic [1:0] fail_output_pins_i, // fail outputs 2 and 3
    input wire logic fail_output_wake_cfg_i, // fail outputs used as inputs
    input wire logic timer_one_window_i, // cyclic timer one on-time
    input wire logic timer_two_window_i, // cyclic timer two on-time
    // results
    output logic [PINS-1:0] pull_up_en_o,
    output logic [PINS-1:0] pull_down_en_o,
    output logic irq_o,
    output logic wake_req_o
);
    import wkd_pkg::*;

    // ==================================================================
    // registers
    logic [PINS-1:0] enable_q; // wake_enable_control
    logic [2*PINS-1:0] pull_q; // pull_source_control
    logic [2*PINS-1:0] filt_q; // detection_filter_control
    logic [PINS+1:0] mask_q; // interrupt mask, a flags then b flags
    logic [PINS-1:0] stat_a_q; // wake_source_status_a
    logic [1:0] stat_b_q; // wake_source_status_b
    logic [PINS-1:0] level_q; // pin_level_status
    logic [1:0] mode_q; // power mode set by the mode controller
    logic ack_q;
    logic [WKD_DW-1:0] rdat_q;
    logic wake_req_q;

    // ==================================================================
    // helpers
    // field of pin n from a packed two-bit-per-pin register
    function automatic logic [1:0] fld(input logic [2*PINS-1:0] r,
                                       input int n);
        fld = r[2*n +: 2];
    endfunction
    // ==================================================================
    // bus decode
    wire logic req = wb_cyc_i && wb_stb_i && !ack_q;
    wire logic wr = req && wb_we_i;
    wire logic hit_en = wb_adr_i == WKD_OFS_ENABLE;
    wire logic hit_sa = wb_adr_i == WKD_OFS_STAT_A;
    wire logic hit_sb = wb_adr_i == WKD_OFS_STAT_B;
    wire logic hit_lv = wb_adr_i == WKD_OFS_LEVEL;
    wire logic hit_pu = wb_adr_i == WKD_OFS_PULL;
    wire logic hit_fl = wb_adr_i == WKD_OFS_FILT;
    wire logic hit_mk = wb_adr_i == WKD_OFS_MASK;
    wire logic hit_md = wb_adr_i == WKD_OFS_MODE;
    wire logic mapped = hit_en | hit_sa | hit_sb | hit_lv | hit_pu
                        | hit_fl | hit_mk | hit_md;
    wire logic lane0 = wb_sel_i[0];
    wire logic [7:0] wbyte = wb_dat_i[7:0];

    // read mux, reserved bits read zero
    logic [WKD_DW-1:0] rmux;
    always_comb begin
        rmux = '0;
        if (hit_en) rmux[PINS-1:0] = enable_q;
        if (hit_sa) rmux[PINS-1:0] = stat_a_q; // R9 readable in any mode
        if (hit_sb) rmux[1:0] = stat_b_q;
        if (hit_lv) rmux[PINS-1:0] = level_q;
        if (hit_pu) rmux[2*PINS-1:0] = pull_q;
        if (hit_fl) rmux[2*PINS-1:0] = filt_q;
        if (hit_mk) rmux[PINS+1:0] = mask_q;
        if (hit_md) rmux[1:0] = mode_q;
    end

    // ==================================================================
    // per-pin detection
    logic [PINS-1:0] win; // evaluation window per pin
    logic [PINS-1:0] cyc; // pin is in cyclic sense
    logic [PINS-1:0] flt_level;
    logic [PINS-1:0] flt_edge;
    logic [WKD_CNT_W-1:0] lim [PINS];
    for (genvar n = 0; n < PINS; n++) begin : g_pin
        wire logic [1:0] det = fld(filt_q, n);
        // R3 static sense always open; R4 cyclic only in timer window
        assign win[n] = (det == WKD_DET_CYC_ONE) ? timer_one_window_i : // R7
                        (det == WKD_DET_CYC_TWO) ? timer_two_window_i : // R7
                        1'b1; // R3
        assign cyc[n] = det[1]; // R4
        // R6 long filter only for code 01, all others short
        assign lim[n] = (det == WKD_DET_STAT_LONG) ?
                        WKD_CNT_W'(WKD_CYC_LONG) : // R6
                        WKD_CNT_W'(WKD_CYC_SHORT); // R6
        wkd_filter #(.CNT_W(WKD_CNT_W)) u_filt (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .pin_i(wake_pin_n_i[n]),
            .window_i(win[n]),
            .limit_i(lim[n]),
            .level_o(flt_level[n]),
            .edge_o(flt_edge[n])
        );
        // R13 pull decode; R14 auto follows the detected level
        wire logic [1:0] pl = fld(pull_q, n);
        assign pull_up_en_o[n] = (pl == WKD_PULL_UP) || // R13
                                 ((pl == WKD_PULL_AUTO) && flt_level[n]); // R14
        assign pull_down_en_o[n] = (pl == WKD_PULL_DOWN) || // R13
                                   ((pl == WKD_PULL_AUTO) && !flt_level[n]);
    end

    // fail-output pins: fixed short static filter
    logic [1:0] fo_edge;
    for (genvar k = 0; k < 2; k++) begin : g_fo
        wkd_filter #(.CNT_W(WKD_CNT_W)) u_fofilt (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .pin_i(fail_output_pins_i[k]),
            .window_i(fail_output_wake_cfg_i), // R12
            .limit_i(WKD_CNT_W'(WKD_CYC_SHORT)), // R12
            .level_o(),
            .edge_o(fo_edge[k])
        );
    end

    // ==================================================================
    // events and mode steering
    wire logic awake = (mode_q == WKD_MODE_NORMAL) || (mode_q == WKD_MODE_STOP);
    wire logic [PINS-1:0] ev_a = flt_edge & enable_q; // R8
    wire logic [1:0] ev_b = fo_edge;
    wire logic [PINS-1:0] clr_a = (wr && hit_sa && lane0) ? wbyte[PINS-1:0] : '0;
    wire logic [1:0] clr_b = (wr && hit_sb && lane0) ? wbyte[1:0] : '0;
    wire logic any_ev = |ev_a || |ev_b;

    // level register: live in static, last window sample in cyclic
    logic [PINS-1:0] level_d;
    always_comb begin
        level_d = level_q;
        for (int n = 0; n < PINS; n++) begin
            if (!cyc[n] || win[n]) level_d[n] = wake_pin_n_i[n]; // R10 R11
        end
    end

    // ==================================================================
    // sticky flags: set wins over a clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stat_a_q <= '0;
            stat_b_q <= '0;
        end else begin
            stat_a_q <= (stat_a_q & ~clr_a) | ev_a; // R9 R15
            stat_b_q <= (stat_b_q & ~clr_b) | ev_b; // R12 R15
        end
    end

    // level capture only while normal or stop, frozen otherwise
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            level_q <= '0;
        end else if (awake) begin
            level_q <= level_d; // R10
        end
    end

    // wake request: raised by an event in sleep or fail-safe, held until
    // the mode controller leaves the low-power mode
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wake_req_q <= 1'b0;
        end else if (awake) begin
            wake_req_q <= 1'b0;
        end else if (any_ev) begin
            wake_req_q <= 1'b1; // R2
        end
    end
    assign wake_req_o = wake_req_q;
    // interrupt only in normal or stop; flags still record in low power
    assign irq_o = awake && |({stat_b_q, stat_a_q} & mask_q); // R2

    // ==================================================================
    // control registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            enable_q <= WKD_RST_ENABLE;
            pull_q <= WKD_RST_PULL; // R13 none at reset
            filt_q <= WKD_RST_FILT;
            mask_q <= WKD_RST_MASK;
            mode_q <= WKD_RST_MODE;
        end else if (wr && lane0) begin
            if (hit_en) enable_q <= wbyte[PINS-1:0];
            if (hit_pu) pull_q <= wbyte[2*PINS-1:0];
            if (hit_fl) filt_q <= wbyte[2*PINS-1:0];
            if (hit_mk) mask_q <= wbyte[PINS+1:0];
            if (hit_md) mode_q <= wbyte[1:0];
        end
    end

    // bus answer: one cycle after the request, dropped the next cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            rdat_q <= '0;
        end else begin
            ack_q <= req;
            rdat_q <= (req && !wb_we_i) ? rmux : '0;
        end
    end
    logic err_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            err_q <= 1'b0;
        end else begin
            err_q <= req && !mapped;
        end
    end
    assign wb_ack_o = ack_q && !err_q;
    assign wb_err_o = ack_q && err_q;
    assign wb_dat_o = rdat_q;

    // ==================================================================
    // checks
    // mode steering
    AST_IRQ_MODE: assert property ( // R2
        @(posedge clk_i) disable iff (rst_i)
        irq_o |-> awake) else $error("interrupt in low power");
    AST_WAKE_REQ: assert property ( // R2
        @(posedge clk_i) disable iff (rst_i)
        (!awake && any_ev) |=> wake_req_o || awake)
        else $error("no wake request");
    AST_WAKE_CLEAR: assert property ( // R2
        @(posedge clk_i) disable iff (rst_i)
        awake |=> !wake_req_o) else $error("wake request kept while awake");
    // flags; pin 1 is the pin left disabled while asleep
    AST_ENABLE_GATE: assert property ( // R8
        @(posedge clk_i) disable iff (rst_i)
        (flt_edge[1] && !enable_q[1] && !stat_a_q[1]) |=> !stat_a_q[1])
        else $error("disabled pin flagged");
    AST_FLAG_SET: assert property ( // R9
        @(posedge clk_i) disable iff (rst_i)
        ev_a[0] |=> stat_a_q[0]) else $error("source flag lost");
    AST_FLAG_HOLD: assert property ( // R15
        @(posedge clk_i) disable iff (rst_i)
        (stat_a_q[0] && !clr_a[0]) |=> stat_a_q[0])
        else $error("flag dropped uncleared");
    AST_STAT_B_SET: assert property ( // R12
        @(posedge clk_i) disable iff (rst_i)
        ev_b[0] |=> stat_b_q[0]) else $error("fail pin flag lost");
    // pulls
    AST_PULL_AUTO: assert property ( // R14
        @(posedge clk_i) disable iff (rst_i)
        fld(pull_q, 2) == WKD_PULL_AUTO |->
        pull_up_en_o[2] == flt_level[2] && pull_down_en_o[2] != flt_level[2])
        else $error("auto pull not following level");
    AST_PULL_NONE: assert property ( // R13
        @(posedge clk_i) disable iff (rst_i)
        fld(pull_q, 1) == WKD_PULL_NONE |->
        !pull_up_en_o[1] && !pull_down_en_o[1])
        else $error("pull on while none");
    // level register
    AST_CYC_HOLD: assert property ( // R11
        @(posedge clk_i) disable iff (rst_i)
        (cyc[2] && !win[2]) |=> $stable(level_q[2]))
        else $error("level moved outside window");
    AST_STATIC_LEVEL: assert property ( // R10
        @(posedge clk_i) disable iff (rst_i)
        (awake && !cyc[0]) |=> level_q[0] == $past(wake_pin_n_i[0]))
        else $error("static level not live");
    AST_LEVEL_FROZEN: assert property ( // R10
        @(posedge clk_i) disable iff (rst_i)
        !awake |=> $stable(level_q)) else $error("level moved in low power");
    // bus
    AST_ACK: assert property ( // bus answer timing
        @(posedge clk_i) disable iff (rst_i)
        req |=> (wb_ack_o || wb_err_o) ##1 !(wb_ack_o || wb_err_o))
        else $error("bus answer timing");
endmodule
`default_nettype wire

// File: test/wkd_switch_model.sv
// model of the switches and sensors that sit on the wake and fail pins
// assumes the bench commands levels on clk_i and comparators are clean
`timescale 1ns/1ps
`default_nettype none
module wkd_switch_model (
    input wire logic clk_i,
    input wire logic [2:0] pin_cmd_i, // commanded switch positions
    input wire logic [1:0] fo_cmd_i, // commanded fail pin levels
    output logic [2:0] wake_pin_n_o, // comparator levels of wake pins
    output logic [1:0] fail_pins_o // comparator levels of fail pins
);
    // ==================================================================
    // contacts
    // registered so a change lands just after an edge, never on it
    always_ff @(posedge clk_i) begin
        wake_pin_n_o <= pin_cmd_i;
        fail_pins_o <= fo_cmd_i;
    end
endmodule
`default_nettype wire

// File: test/testbench.sv
// self-checking bench for the wake input detector: wishbone tasks
// assumes the package, wkd_core and the switch model are compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
    $display("ERROR %0t: got %0h exp %0h", $time, g, e); end end
module testbench;
    import wkd_pkg::*;
    // ==================================================================
    // signals
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0; // bus request
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic wb_err_o;
    logic [2:0] pcmd = 3'h0; // switch commands to the model
    logic [1:0] fcmd = 2'h0;
    logic cfg = 1'b0; // fail pins used as wake inputs
    logic [1:0] win = 2'h0; // cyclic timer windows
    logic [2:0] pins;
    logic [1:0] fpins;
    logic [2:0] up;
    logic [2:0] dn;
    logic irq;
    logic wake;
    logic [31:0] rdat; // data taken at the falling edge that sees the ack
    logic berr; // error answer seen
    int miscompares = 0;
    int tests_run = 0;
    // ==================================================================
    // clock and instances
    initial begin
        forever #20 clk_i = ~clk_i;
    end
    wkd_switch_model sw (.clk_i(clk_i), .pin_cmd_i(pcmd), .fo_cmd_i(fcmd),
        .wake_pin_n_o(pins), .fail_pins_o(fpins));
    wkd_core dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1),
        .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .wb_err_o(wb_err_o), .wake_pin_n_i(pins), .fail_output_pins_i(fpins),
        .fail_output_wake_cfg_i(cfg), .timer_one_window_i(win[0]),
        .timer_two_window_i(win[1]), .pull_up_en_o(up),
        .pull_down_en_o(dn), .irq_o(irq), .wake_req_o(wake));
    // ==================================================================
    // tasks
    task results;
        begin
            $display("checks %0d mismatches %0d", tests_run, miscompares);
            if (miscompares == 0 && tests_run > 0) begin
                $display("TB: PASS");
            end else begin
                $display("TB: FAIL");
            end
            $finish;
        end
    endtask
    // one classic cycle; ack is looked at once settled, release follows
    // the rising edge that sampled it, so one idle cycle sits between
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        begin
            @(posedge clk_i);
            cyc <= 1'b1;
            stb <= 1'b1;
            we <= w;
            adr <= a;
            wdat <= d;
            n = 0;
            do begin
                @(negedge clk_i);
                n++;
            end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20);
            if (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1) begin
                miscompares++;
                results();
            end
            rdat = wb_dat_o;
            berr = wb_err_o;
            @(posedge clk_i);
            cyc <= 1'b0;
            stb <= 1'b0;
            we <= 1'b0;
        end
    endtask
    task rchk(input logic [7:0] a, input logic [31:0] e);
        begin
            bus(1'b0, a, 32'h0);
            `CHK(rdat, e)
        end
    endtask
    task wt(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task pin(input logic [2:0] v);
        begin
            @(posedge clk_i);
            pcmd <= v;
        end
    endtask
    // ==================================================================
    // main sequence
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        // every register comes up zero, an unmapped place answers err
        for (int i = 0; i < 8; i++) begin
            rchk(8'(i * 4), 32'h0);
        end
        bus(1'b0, 8'h20, 32'h0);
        `CHK(berr, 1'b1)
        @(negedge clk_i);
        `CHK({up, dn, irq, wake}, 8'h00)
        bus(1'b1, WKD_OFS_ENABLE, 32'h7);
        bus(1'b1, WKD_OFS_MASK, 32'h7);
        // rising edge: not before the filter, then flagged with irq
        pin(3'b001);
        wt(380);
        rchk(WKD_OFS_STAT_A, 32'h0);
        wt(40);
        rchk(WKD_OFS_STAT_A, 32'h1);
        @(negedge clk_i);
        `CHK(irq, 1'b1)
        // a pulse shorter than the filter is dropped
        pin(3'b011);
        wt(200);
        pin(3'b001);
        wt(420);
        rchk(WKD_OFS_STAT_A, 32'h1);
        bus(1'b1, WKD_OFS_STAT_A, 32'h1);
        rchk(WKD_OFS_STAT_A, 32'h0);
        // falling edge with the mask closed, then opened
        bus(1'b1, WKD_OFS_MASK, 32'h0);
        pin(3'b000);
        wt(420);
        rchk(WKD_OFS_STAT_A, 32'h1);
        @(negedge clk_i);
        `CHK(irq, 1'b0)
        bus(1'b1, WKD_OFS_MASK, 32'h7);
        @(negedge clk_i);
        `CHK(irq, 1'b1)
        bus(1'b1, WKD_OFS_STAT_A, 32'h1);
        // long static filter on pin 0
        bus(1'b1, WKD_OFS_FILT, 32'h1);
        pin(3'b001);
        wt(1500);
        rchk(WKD_OFS_STAT_A, 32'h0);
        wt(120);
        rchk(WKD_OFS_STAT_A, 32'h1);
        bus(1'b1, WKD_OFS_STAT_A, 32'h1);
        bus(1'b1, WKD_OFS_FILT, 32'h0);
        rchk(WKD_OFS_LEVEL, 32'h1);
        // pin 0 down, pin 1 up, pin 2 automatic following its level
        bus(1'b1, WKD_OFS_PULL, 32'h39);
        @(negedge clk_i);
        `CHK({up, dn}, 6'b010_101)
        pin(3'b101);
        wt(420);
        @(negedge clk_i);
        `CHK({up, dn}, 6'b110_001)
        bus(1'b1, WKD_OFS_STAT_A, 32'h4);
        // cyclic sense on pin 2 with each timer in turn
        for (int k = 0; k < 2; k++) begin
            bus(1'b1, WKD_OFS_FILT, 32'(2 + k) << 4);
            pin((k == 1) ? 3'b101 : 3'b001);
            wt(500);
            rchk(WKD_OFS_STAT_A, 32'h0);
            rchk(WKD_OFS_LEVEL, (k == 1) ? 32'h1 : 32'h5);
            @(posedge clk_i);
            win <= (k == 1) ? 2'b10 : 2'b01;
            wt(420);
            rchk(WKD_OFS_STAT_A, 32'h4);
            rchk(WKD_OFS_LEVEL, (k == 1) ? 32'h5 : 32'h1);
            @(posedge clk_i);
            win <= 2'b00;
            bus(1'b1, WKD_OFS_STAT_A, 32'h4);
        end
        // sleep: disabled pin is ignored, enabled pin wakes
        bus(1'b1, WKD_OFS_MODE, 32'h2);
        bus(1'b1, WKD_OFS_ENABLE, 32'h5);
        pin(3'b111);
        wt(420);
        rchk(WKD_OFS_STAT_A, 32'h0);
        @(negedge clk_i);
        `CHK({irq, wake}, 2'b00)
        pin(3'b110);
        wt(420);
        rchk(WKD_OFS_STAT_A, 32'h1);
        @(negedge clk_i);
        `CHK({irq, wake}, 2'b01)
        bus(1'b1, WKD_OFS_MODE, 32'h0);
        @(negedge clk_i);
        `CHK({irq, wake}, 2'b10)
        // stop still interrupts, fail-safe holds it off
        bus(1'b1, WKD_OFS_MODE, 32'h1);
        @(negedge clk_i);
        `CHK({irq, wake}, 2'b10)
        bus(1'b1, WKD_OFS_MODE, 32'h3);
        @(negedge clk_i);
        `CHK({irq, wake}, 2'b00)
        bus(1'b1, WKD_OFS_MODE, 32'h0);
        bus(1'b1, WKD_OFS_STAT_A, 32'h1);
        // fail pins as wake inputs, short filter, second status
        bus(1'b1, WKD_OFS_MASK, 32'h1f);
        @(posedge clk_i);
        cfg <= 1'b1;
        fcmd <= 2'b01;
        wt(380);
        rchk(WKD_OFS_STAT_B, 32'h0);
        wt(40);
        rchk(WKD_OFS_STAT_B, 32'h1);
        @(negedge clk_i);
        `CHK(irq, 1'b1)
        bus(1'b1, WKD_OFS_STAT_B, 32'h1);
        rchk(WKD_OFS_STAT_B, 32'h0);
        results();
    end
endmodule
`default_nettype wire
